// >>> sefp_pkg.sv
// Constants, register map and types of the supply pin controller
package sefp_pkg;

    // ----------------------------------------------------------------
    // Sizes
    // ----------------------------------------------------------------
    localparam int NUM_SEN = 12;
    localparam int NUM_PWM = 8;
    localparam int NUM_FLT = 3;
    localparam int DUTY_W = 8;
    localparam int ADDR_W = 8;
    localparam int INT_W = 4;

    // ----------------------------------------------------------------
    // Register offsets (byte addresses; OFF_DUTY_HI is the paddr[7:5] value of the duty block)
    // ----------------------------------------------------------------
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_SEN_POL = 8'h04;
    localparam logic [7:0] OFF_SEN_PP = 8'h08;
    localparam logic [7:0] OFF_SEN_GPO = 8'h0C;
    localparam logic [7:0] OFF_SEN_VAL = 8'h10;
    localparam logic [7:0] OFF_PWM_MEN = 8'h14;
    localparam logic [7:0] OFF_PWM_GPO = 8'h18;
    localparam logic [7:0] OFF_PWM_GVAL = 8'h1C;
    localparam logic [2:0] OFF_DUTY_HI = 3'h1;
    localparam logic [7:0] OFF_FLT_ASRT0 = 8'h40;
    localparam logic [7:0] OFF_FLT_SHUT0 = 8'h4C;
    localparam logic [7:0] OFF_STATUS = 8'h58;
    localparam logic [7:0] OFF_INT_STAT = 8'h5C;
    localparam logic [7:0] OFF_INT_MASK = 8'h60;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int CTRL_RECALL = 0;
    localparam int CTRL_MON = 1;
    localparam int CTRL_SHCLR = 2;
    localparam int STAT_LINE = 2;
    localparam int STAT_SHUT = 16;
    localparam int INT_SHUT = 3;

    // ----------------------------------------------------------------
    // Reset values and full-scale duty
    // ----------------------------------------------------------------
    localparam logic [11:0] RST_SEN_POL = 12'hFFF;
    localparam logic [DUTY_W-1:0] DUTY_FULL = 8'hFF;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 100;
    localparam int PWM_STEP_NS = 1000;
    localparam int PWM_DIV = (PWM_STEP_NS + CLK_PERIOD_NS - 1)
                             / CLK_PERIOD_NS;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [1:0]
    {
        ST_OFF = 2'b00,
        ST_HOLD = 2'b01,
        ST_MON = 2'b10
    } sefp_state_t;

endpackage : sefp_pkg

// >>> sefp_sen_pin.sv
// One supply-enable pin: polarity, drive type and general output reuse
`timescale 1ns/1ps
module sefp_sen_pin
    import sefp_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic active,
    input wire logic pol_high,
    input wire logic push_pull,
    input wire logic gpo_mode,
    input wire logic gpo_val,
    input wire logic enable_req,
    output logic pin_o,
    output logic pin_oe
);

    logic level;
    logic nxt_o;
    logic nxt_oe;
    logic pin_o_ff;
    logic pin_oe_ff;

    // Enable request mapped to the asserted level [R1] [R3]
    assign level = gpo_mode ? gpo_val : (enable_req ~^ pol_high);
    // Open drain only ever pulls low [R2] [R13]
    assign nxt_o = push_pull ? level : 1'b0;
    assign nxt_oe = active & (push_pull | ~level);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pin_o_ff <= 1'b0;
            pin_oe_ff <= 1'b0;
        end
        else
        begin
            pin_o_ff <= nxt_o;
            pin_oe_ff <= nxt_oe;
        end
    end

    assign pin_o = pin_o_ff;
    assign pin_oe = pin_oe_ff;

endmodule : sefp_sen_pin

// >>> sefp_pwm_pin.sv
// One margining PWM pin with high impedance and general output reuse
`timescale 1ns/1ps
module sefp_pwm_pin
    import sefp_pkg::*;
#(
    parameter int DW = DUTY_W
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic active,
    input wire logic margin_en,
    input wire logic gpo_mode,
    input wire logic gpo_val,
    input wire logic [DW-1:0] duty,
    input wire logic [DW-1:0] phase,
    output logic pin_o,
    output logic pin_oe
);

    logic nxt_o;
    logic nxt_oe;
    logic pin_o_ff;
    logic pin_oe_ff;

    // Phase stops one short of full scale, so full duty never goes low
    // and zero duty never goes high [R6] [R16]
    assign nxt_o = gpo_mode ? gpo_val : (phase < duty); // [R7]
    assign nxt_oe = active & (gpo_mode | margin_en); // [R5] [R13]

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pin_o_ff <= 1'b0;
            pin_oe_ff <= 1'b0;
        end
        else
        begin
            pin_o_ff <= nxt_o;
            pin_oe_ff <= nxt_oe;
        end
    end

    assign pin_o = pin_o_ff;
    assign pin_oe = pin_oe_ff;

endmodule : sefp_pwm_pin

// >>> sefp_top.sv
// Supply-enable, margin PWM and shared fault line control with APB
// Operation
// R1 - Each supply-enable pin has its own asserted-level polarity.
// R2 - Each supply-enable pin drives open drain or push-pull.
// R3 - Each supply-enable pin can be reused as a general output.
// R4 - The board fits pulls that hold supplies off when undriven.
// R5 - A PWM pin floats whenever its margining is disabled; a pin in general output mode is driven even with margining disabled.
// R6 - Full duty holds the PWM pin continuously high.
// R7 - Each PWM pin can be reused as a general output.
// R8 - Each channel picks which of three fault lines its fault asserts.
// R9 - Each channel picks which asserted fault lines shut it down.
// R10 - Fault lines are released throughout reset.
// R11 - After recall, all fault lines are pulled low until monitoring.
// R12 - At monitoring start a line is released unless a mapped fault.
// R13 - All pins float during power-up and reset.
// R14 - Fault lines are wired among several managers.
// R15 - Fault lines are active-low open-drain, sensed as inputs.
// R16 - Zero duty holds an enabled PWM pin continuously low.
//
// Design decisions made here: register access over APB and the placing of the registers.
`timescale 1ns/1ps
module sefp_top
    import sefp_pkg::*;
#(
    parameter int PWM_DIVIDE = PWM_DIV
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [NUM_SEN-1:0] ch_fault,
    input wire logic [NUM_FLT-1:0] shared_fault_line_i,
    output logic [NUM_FLT-1:0] shared_fault_line_o,
    output logic [NUM_FLT-1:0] shared_fault_line_oe,
    output logic [NUM_SEN-1:0] supply_enable_out_o,
    output logic [NUM_SEN-1:0] supply_enable_out_oe,
    output logic [NUM_PWM-1:0] margin_pwm_o,
    output logic [NUM_PWM-1:0] margin_pwm_oe,
    output logic [NUM_SEN-1:0] ch_shutdown,
    output logic irq
);

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    sefp_state_t st_ff;
    sefp_state_t nxt_st;
    logic [2:0] ctrl_ff;
    logic [NUM_SEN-1:0] sen_pol_ff;
    logic [NUM_SEN-1:0] sen_pp_ff;
    logic [NUM_SEN-1:0] sen_gpo_ff;
    logic [NUM_SEN-1:0] sen_val_ff;
    logic [NUM_PWM-1:0] pwm_men_ff;
    logic [NUM_PWM-1:0] pwm_gpo_ff;
    logic [NUM_PWM-1:0] pwm_gval_ff;
    logic [DUTY_W-1:0] duty_ff [NUM_PWM];
    logic [NUM_SEN-1:0] flt_asrt_ff [NUM_FLT];
    logic [NUM_SEN-1:0] flt_shut_ff [NUM_FLT];
    logic [NUM_SEN-1:0] shut_ff;
    logic [NUM_FLT-1:0] seen_ff;
    logic [NUM_FLT-1:0] flt_oe_ff;
    logic [NUM_FLT-1:0] flt_o_ff;
    logic [INT_W-1:0] int_stat_ff;
    logic [INT_W-1:0] int_mask_ff;
    logic irq_ff;
    logic [31:0] prdata_ff;
    logic pready_ff;
    logic pslverr_ff;
    logic [15:0] div_ff;
    logic [DUTY_W-1:0] phase_ff;

    // ----------------------------------------------------------------
    // Bus decode
    // ----------------------------------------------------------------
    logic setup;
    logic wr;
    logic duty_hit;
    logic flt_hit;
    logic hit;
    logic [31:0] rd_mux;
    logic [NUM_FLT-1:0] asrt_sel;
    logic [NUM_FLT-1:0] shut_sel;

    assign setup = psel & ~penable;
    assign wr = psel & penable & pwrite & pready_ff;
    assign duty_hit = (paddr[7:5] == OFF_DUTY_HI);
    assign flt_hit = (|asrt_sel) | (|shut_sel);
    assign hit = duty_hit | flt_hit | (paddr == OFF_CTRL)
        | (paddr == OFF_SEN_POL) | (paddr == OFF_SEN_PP)
        | (paddr == OFF_SEN_GPO) | (paddr == OFF_SEN_VAL)
        | (paddr == OFF_PWM_MEN) | (paddr == OFF_PWM_GPO)
        | (paddr == OFF_PWM_GVAL) | (paddr == OFF_STATUS)
        | (paddr == OFF_INT_STAT) | (paddr == OFF_INT_MASK);

    genvar g;
    generate
        for (g = 0; g < NUM_FLT; g++)
        begin : g_fsel
            assign asrt_sel[g] = (paddr == OFF_FLT_ASRT0 + 8'(4 * g));
            assign shut_sel[g] = (paddr == OFF_FLT_SHUT0 + 8'(4 * g));
        end
    endgenerate

    always_comb
    begin
        rd_mux = 32'h0000_0000;
        if (duty_hit)
            rd_mux[DUTY_W-1:0] = duty_ff[paddr[4:2]];
        for (int i = 0; i < NUM_FLT; i++)
        begin
            if (asrt_sel[i])
                rd_mux[NUM_SEN-1:0] = flt_asrt_ff[i];
            if (shut_sel[i])
                rd_mux[NUM_SEN-1:0] = flt_shut_ff[i];
        end
        case (paddr)
            OFF_CTRL: rd_mux[2:0] = ctrl_ff;
            OFF_SEN_POL: rd_mux[NUM_SEN-1:0] = sen_pol_ff;
            OFF_SEN_PP: rd_mux[NUM_SEN-1:0] = sen_pp_ff;
            OFF_SEN_GPO: rd_mux[NUM_SEN-1:0] = sen_gpo_ff;
            OFF_SEN_VAL: rd_mux[NUM_SEN-1:0] = sen_val_ff;
            OFF_PWM_MEN: rd_mux[NUM_PWM-1:0] = pwm_men_ff;
            OFF_PWM_GPO: rd_mux[NUM_PWM-1:0] = pwm_gpo_ff;
            OFF_PWM_GVAL: rd_mux[NUM_PWM-1:0] = pwm_gval_ff;
            OFF_STATUS:
            begin
                rd_mux[1:0] = st_ff;
                rd_mux[STAT_LINE +: NUM_FLT] = seen_ff;
                rd_mux[STAT_SHUT +: NUM_SEN] = shut_ff;
            end
            OFF_INT_STAT: rd_mux[INT_W-1:0] = int_stat_ff;
            OFF_INT_MASK: rd_mux[INT_W-1:0] = int_mask_ff;
            default: ;
        endcase
    end

    // Answer one cycle after setup, so pready is high on the first
    // access edge; unmapped addresses answer with an error
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h0000_0000;
        end
        else
        begin
            pready_ff <= setup;
            pslverr_ff <= setup & ~hit;
            prdata_ff <= (setup & ~pwrite) ? rd_mux : 32'h0000_0000;
        end
    end

    // ----------------------------------------------------------------
    // Configuration writes
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_ff <= 3'h0;
            sen_pol_ff <= RST_SEN_POL;
            sen_pp_ff <= '0;
            sen_gpo_ff <= '0;
            sen_val_ff <= '0;
            pwm_men_ff <= '0;
            pwm_gpo_ff <= '0;
            pwm_gval_ff <= '0;
            int_mask_ff <= '0;
        end
        else
        begin
            ctrl_ff[CTRL_SHCLR] <= 1'b0;
            if (wr && paddr == OFF_CTRL)
                ctrl_ff <= pwdata[2:0];
            if (wr && paddr == OFF_SEN_POL)
                sen_pol_ff <= pwdata[NUM_SEN-1:0];
            if (wr && paddr == OFF_SEN_PP)
                sen_pp_ff <= pwdata[NUM_SEN-1:0];
            if (wr && paddr == OFF_SEN_GPO)
                sen_gpo_ff <= pwdata[NUM_SEN-1:0];
            if (wr && paddr == OFF_SEN_VAL)
                sen_val_ff <= pwdata[NUM_SEN-1:0];
            if (wr && paddr == OFF_PWM_MEN)
                pwm_men_ff <= pwdata[NUM_PWM-1:0];
            if (wr && paddr == OFF_PWM_GPO)
                pwm_gpo_ff <= pwdata[NUM_PWM-1:0];
            if (wr && paddr == OFF_PWM_GVAL)
                pwm_gval_ff <= pwdata[NUM_PWM-1:0];
            if (wr && paddr == OFF_INT_MASK)
                int_mask_ff <= pwdata[INT_W-1:0];
        end
    end

    generate
        for (g = 0; g < NUM_PWM; g++)
        begin : g_duty
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                    duty_ff[g] <= '0;
                else if (wr && duty_hit && paddr[4:2] == 3'(g))
                    duty_ff[g] <= pwdata[DUTY_W-1:0];
            end
        end
        for (g = 0; g < NUM_FLT; g++)
        begin : g_fmap
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    flt_asrt_ff[g] <= '0;
                    flt_shut_ff[g] <= '0;
                end
                else
                begin
                    if (wr && asrt_sel[g])
                        flt_asrt_ff[g] <= pwdata[NUM_SEN-1:0];
                    if (wr && shut_sel[g])
                        flt_shut_ff[g] <= pwdata[NUM_SEN-1:0];
                end
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // Recall / monitoring sequence
    // ----------------------------------------------------------------
    always_comb
    begin
        case (st_ff)
            ST_OFF: nxt_st = ctrl_ff[CTRL_RECALL] ? ST_HOLD : ST_OFF;
            ST_HOLD: nxt_st = ctrl_ff[CTRL_MON] ? ST_MON : ST_HOLD;
            ST_MON: nxt_st = ctrl_ff[CTRL_MON] ? ST_MON : ST_HOLD;
            default: nxt_st = ST_OFF;
        endcase
        if (!ctrl_ff[CTRL_RECALL])
            nxt_st = ST_OFF;
    end

    // ----------------------------------------------------------------
    // Fault lines
    // ----------------------------------------------------------------
    logic [NUM_FLT-1:0] line_now;
    logic [NUM_FLT-1:0] flt_req;
    logic [NUM_FLT-1:0] nxt_flt_oe;
    logic [NUM_SEN-1:0] shut_cause;
    logic [NUM_SEN-1:0] nxt_shut;
    logic [INT_W-1:0] int_set;
    logic [INT_W-1:0] nxt_int;
    logic active;

    // Low on the wire means asserted, whoever pulls it [R14] [R15]
    assign line_now = ~shared_fault_line_i;
    assign active = (st_ff != ST_OFF);

    generate
        for (g = 0; g < NUM_FLT; g++)
        begin : g_req
            assign flt_req[g] = |(flt_asrt_ff[g] & ch_fault); // [R8]
        end
        for (g = 0; g < NUM_SEN; g++)
        begin : g_cause
            logic [NUM_FLT-1:0] sel;
            for (genvar l = 0; l < NUM_FLT; l++)
            begin : g_l
                assign sel[l] = flt_shut_ff[l][g];
            end
            // Ignored before monitoring, when our own hold pulls low
            assign shut_cause[g] = (st_ff == ST_MON)
                & (|(sel & line_now)); // [R9]
        end
    endgenerate

    // Released in reset, all low after recall, fault-driven later
    assign nxt_flt_oe = (st_ff == ST_HOLD) ? '1 // [R11]
        : (st_ff == ST_MON) ? flt_req // [R12]
        : '0; // [R10]

    // A new cause wins over a same-cycle software clear
    assign nxt_shut = (shut_ff & {NUM_SEN{~ctrl_ff[CTRL_SHCLR]}})
        | shut_cause;
    assign int_set = {|(shut_cause & ~shut_ff), line_now & ~seen_ff};
    assign nxt_int = (int_stat_ff
        & ~((wr && paddr == OFF_INT_STAT) ? pwdata[INT_W-1:0] : '0))
        | int_set;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_ff <= ST_OFF;
            seen_ff <= '0;
            flt_oe_ff <= '0; // [R10]
            flt_o_ff <= '0;
            shut_ff <= '0;
            int_stat_ff <= '0;
            irq_ff <= 1'b0;
        end
        else
        begin
            st_ff <= nxt_st;
            seen_ff <= line_now;
            flt_oe_ff <= nxt_flt_oe;
            shut_ff <= nxt_shut;
            int_stat_ff <= nxt_int;
            irq_ff <= |(nxt_int & int_mask_ff);
        end
    end

    // ----------------------------------------------------------------
    // PWM time base
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            div_ff <= '0;
            phase_ff <= '0;
        end
        else if (div_ff == 16'(PWM_DIVIDE - 1))
        begin
            div_ff <= '0;
            // Wraps before full scale so full duty has no low phase
            phase_ff <= (phase_ff == DUTY_FULL - 8'h01) ? '0
                : phase_ff + 8'h01; // [R6]
        end
        else
            div_ff <= div_ff + 16'h0001;
    end

    // ----------------------------------------------------------------
    // Pins
    // ----------------------------------------------------------------
    generate
        for (g = 0; g < NUM_SEN; g++)
        begin : g_sen
            sefp_sen_pin u_sen (
                .pclk(pclk),
                .presetn(presetn),
                .active(active), // [R13]
                .pol_high(sen_pol_ff[g]), // [R1]
                .push_pull(sen_pp_ff[g]), // [R2]
                .gpo_mode(sen_gpo_ff[g]), // [R3]
                .gpo_val(sen_val_ff[g]),
                .enable_req(sen_val_ff[g] & ~shut_ff[g]), // [R9]
                .pin_o(supply_enable_out_o[g]),
                .pin_oe(supply_enable_out_oe[g])
            );
        end
        for (g = 0; g < NUM_PWM; g++)
        begin : g_pwm
            sefp_pwm_pin #(.DW(DUTY_W)) u_pwm (
                .pclk(pclk),
                .presetn(presetn),
                .active(active), // [R13]
                .margin_en(pwm_men_ff[g]), // [R5]
                .gpo_mode(pwm_gpo_ff[g]), // [R7]
                .gpo_val(pwm_gval_ff[g]),
                .duty(duty_ff[g]),
                .phase(phase_ff),
                .pin_o(margin_pwm_o[g]),
                .pin_oe(margin_pwm_oe[g])
            );
        end
    endgenerate

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign shared_fault_line_o = flt_o_ff;
    assign shared_fault_line_oe = flt_oe_ff;
    assign ch_shutdown = shut_ff;
    assign irq = irq_ff;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    property p_flt_off;
        @(posedge pclk) disable iff (!presetn)
        (st_ff == ST_OFF) |=> (shared_fault_line_oe == '0);
    endproperty
    a_flt_off: assert property (p_flt_off) // [R10]
        else $error("fault line driven before recall");

    property p_flt_hold;
        @(posedge pclk) disable iff (!presetn)
        (st_ff == ST_HOLD) |=> (&shared_fault_line_oe)
            && (shared_fault_line_o == '0);
    endproperty
    a_flt_hold: assert property (p_flt_hold) // [R11]
        else $error("fault lines not held low before monitoring");

    property p_flt_rel;
        @(posedge pclk) disable iff (!presetn)
        (st_ff == ST_MON && flt_req == '0)
            |=> (shared_fault_line_oe == '0);
    endproperty
    a_flt_rel: assert property (p_flt_rel) // [R12]
        else $error("fault line not released in monitoring");

    property p_flt_map;
        @(posedge pclk) disable iff (!presetn)
        (st_ff == ST_MON && ch_fault[0] && flt_asrt_ff[1][0])
            |=> shared_fault_line_oe[1];
    endproperty
    a_flt_map: assert property (p_flt_map) // [R8]
        else $error("mapped channel fault did not assert its line");

    property p_shut;
        @(posedge pclk) disable iff (!presetn)
        (st_ff == ST_MON && !shared_fault_line_i[1] && flt_shut_ff[1][5])
            |=> ch_shutdown[5] ##1 !supply_enable_out_o[5]
                || !supply_enable_out_oe[5] || !sen_pol_ff[5]
                || sen_gpo_ff[5];
    endproperty
    a_shut: assert property (p_shut) // [R9]
        else $error("asserted line did not shut channel down");

    property p_pins_off;
        @(posedge pclk) disable iff (!presetn)
        (st_ff == ST_OFF) |=> (supply_enable_out_oe == '0)
            && (margin_pwm_oe == '0);
    endproperty
    a_pins_off: assert property (p_pins_off) // [R13]
        else $error("pin driven during reset");

    property p_pwm_hiz;
        @(posedge pclk) disable iff (!presetn)
        (!pwm_men_ff[3] && !pwm_gpo_ff[3]) |=> !margin_pwm_oe[3];
    endproperty
    a_pwm_hiz: assert property (p_pwm_hiz) // [R5]
        else $error("pwm pin driven with margining off");

    property p_pwm_full;
        @(posedge pclk) disable iff (!presetn)
        (pwm_men_ff[0] && !pwm_gpo_ff[0] && duty_ff[0] == DUTY_FULL)
            [*2] |=> margin_pwm_o[0];
    endproperty
    a_pwm_full: assert property (p_pwm_full) // [R6]
        else $error("full duty pwm went low");

    property p_pwm_zero;
        @(posedge pclk) disable iff (!presetn)
        (!pwm_gpo_ff[0] && duty_ff[0] == '0) |=> !margin_pwm_o[0];
    endproperty
    a_pwm_zero: assert property (p_pwm_zero) // [R16]
        else $error("zero duty pwm went high");

    property p_od;
        @(posedge pclk) disable iff (!presetn)
        (!sen_pp_ff[4]) |=> !supply_enable_out_o[4];
    endproperty
    a_od: assert property (p_od) // [R2]
        else $error("open-drain enable drove high");

endmodule : sefp_top

// >>> sefp_far.sv
// Far-side model: wired fault lines with pull-ups and peer managers
`timescale 1ns/1ps
module sefp_far
    import sefp_pkg::*;
(
    input wire logic [NUM_FLT-1:0] drv_oe,
    input wire logic [NUM_FLT-1:0] drv_o,
    input wire logic [NUM_FLT-1:0] peer_pull,
    output logic [NUM_FLT-1:0] line
);
    // Pull-up keeps a released wire high; any party may pull it low
    assign line = ~((drv_oe & ~drv_o) | peer_pull);
endmodule : sefp_far

// >>> tb.sv
// Self-checking bench of the supply pin controller
`timescale 1ns/1ps
module tb
    import sefp_pkg::*;
;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, pready, pslverr, irq, e;
    logic [7:0] paddr = 8'h00, pwm_o, pwm_oe, ao, oo;
    logic [31:0] pwdata = 32'h0000_0000, prdata, r;
    logic [31:0] s = 32'h0001_2BA9;
    logic [11:0] ch_fault = 12'h000, sen_o, sen_oe, ch_shutdown;
    logic [11:0] pol, pp, g, v, sen_pin;
    logic [2:0] pull = 3'h0, fl_i, fl_o, fl_oe;
    int mismatches = 0, checks = 0;

    always #50 pclk = ~pclk;

    sefp_top #(.PWM_DIVIDE(1)) u_dut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ch_fault(ch_fault),
        .shared_fault_line_i(fl_i), .shared_fault_line_o(fl_o),
        .shared_fault_line_oe(fl_oe), .supply_enable_out_o(sen_o),
        .supply_enable_out_oe(sen_oe), .margin_pwm_o(pwm_o),
        .margin_pwm_oe(pwm_oe), .ch_shutdown(ch_shutdown), .irq(irq));

    sefp_far u_far (.drv_oe(fl_oe), .drv_o(fl_o), .peer_pull(pull),
        .line(fl_i));

    // Board pull-downs hold active-high supplies off when undriven
    assign sen_pin = sen_oe & sen_o;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    task summarize;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : summarize

    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("mismatch at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : chk

    // Holds the request until pready is seen high at a rising edge
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1)
        begin
            mismatches++;
            summarize();
        end
    endtask : apb

    task cyc(input int k);
        repeat (k) @(posedge pclk);
    endtask : cyc

    function automatic logic [31:0] rnd();
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        s = s ^ (s << 5);
        return s;
    endfunction : rnd

    // Returns {drive enable, driven level} of one enable pin
    function automatic logic [1:0] sen_exp(input logic p, q, gp, vl);
        logic l;
        l = gp ? vl : (vl ? p : ~p);
        return {q | ~l, q & l};
    endfunction : sen_exp

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial
    begin
        cyc(6);
        chk({fl_oe, sen_oe, pwm_oe}, 32'h0);
        presetn <= 1'b1;
        ch_fault <= 12'h004;
        apb(1'b1, OFF_FLT_ASRT0 + 8'h08, 32'h0000_0004);
        apb(1'b1, OFF_CTRL, 32'h0000_0001);
        cyc(3);
        chk(fl_oe, 3'h7);
        apb(1'b1, OFF_CTRL, 32'h0000_0003);
        cyc(3);
        chk(fl_oe, 3'h4);
        ch_fault <= 12'h000;
        cyc(3);
        chk(fl_oe, 3'h0);
        repeat (6)
        begin
            pol = 12'(rnd());
            pp = 12'(rnd());
            g = 12'(rnd());
            v = 12'(rnd());
            apb(1'b1, OFF_SEN_POL, {20'h0, pol});
            apb(1'b1, OFF_SEN_PP, {20'h0, pp});
            apb(1'b1, OFF_SEN_GPO, {20'h0, g});
            apb(1'b1, OFF_SEN_VAL, {20'h0, v});
            cyc(2);
            for (int i = 0; i < NUM_SEN; i++)
                chk({sen_oe[i], sen_oe[i] & sen_o[i]},
                    sen_exp(pol[i], pp[i], g[i], v[i]));
        end
        apb(1'b1, OFF_PWM_MEN, 32'h0000_000F);
        apb(1'b1, OFF_PWM_GPO, 32'h0000_0030);
        apb(1'b1, OFF_PWM_GVAL, 32'h0000_0020);
        apb(1'b1, 8'h20, {24'h0, DUTY_FULL});
        apb(1'b1, 8'h24, 32'h0000_0000);
        apb(1'b1, 8'h28, rnd() & 32'h0000_00FF);
        cyc(2);
        ao = 8'hFF;
        oo = 8'h00;
        repeat (300)
        begin
            @(posedge pclk);
            ao = ao & pwm_o;
            oo = oo | pwm_o;
        end
        chk(pwm_oe, 8'h3F);
        chk(ao & 8'h21, 8'h21);
        chk(oo & 8'h12, 8'h00);
        apb(1'b1, OFF_SEN_GPO, 32'h0000_0000);
        apb(1'b1, OFF_SEN_POL, 32'h0000_0FFF);
        apb(1'b1, OFF_SEN_PP, 32'h0000_0FFF);
        apb(1'b1, OFF_SEN_VAL, 32'h0000_0FFF);
        apb(1'b1, OFF_FLT_ASRT0, 32'h0000_0001);
        apb(1'b1, OFF_FLT_SHUT0 + 8'h04, 32'h0000_0020);
        apb(1'b1, OFF_INT_MASK, 32'h0000_000F);
        ch_fault <= 12'h001;
        cyc(3);
        chk({fl_oe, fl_o}, 6'b001_000);
        pull <= 3'h2;
        cyc(4);
        chk({ch_shutdown[5], sen_o[5], irq}, 3'b101);
        apb(1'b0, OFF_INT_STAT, 32'h0000_0000);
        chk(r[INT_SHUT], 1'b1);
        apb(1'b1, OFF_INT_MASK, 32'h0000_0000);
        cyc(2);
        chk(irq, 1'b0);
        apb(1'b1, OFF_INT_MASK, 32'h0000_000F);
        cyc(2);
        chk(irq, 1'b1);
        ch_fault <= 12'h000;
        pull <= 3'h0;
        cyc(3);
        apb(1'b1, OFF_INT_STAT, 32'h0000_000F);
        cyc(2);
        chk(irq, 1'b0);
        apb(1'b1, OFF_CTRL, 32'h0000_0007);
        cyc(3);
        chk({ch_shutdown[5], sen_o[5]}, 2'b01);
        apb(1'b0, 8'hFC, 32'h0000_0000);
        chk({e, r[30:0]}, 32'h8000_0000);
        ch_fault <= 12'h001;
        cyc(3);
        presetn <= 1'b0;
        cyc(1);
        chk({fl_oe, sen_oe, pwm_oe}, 32'h0);
        chk(sen_pin, 12'h000);
        summarize();
    end
endmodule : tb
